// file: rtl/pap_pkg.sv
// package for the program access protection block: register map, configuration
// byte layout, serial frame layout and command codes.
// assumes a single 32-bit AHB-Lite slave port and an 8-bit configuration space.
package pap_pkg;

  // AHB register byte offsets
  localparam logic [7:0] REG_CFG   = 8'h00;
  localparam logic [7:0] REG_CMD   = 8'h04;
  localparam logic [7:0] REG_RDATA = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0c;

  // configuration byte indices and bit positions (protection bits act when 0)
  localparam int CFG_BYTES      = 8;
  localparam int ID_BYTES       = 8;
  localparam logic [2:0] CFG_4L = 3'h0;
  localparam logic [2:0] CFG_CP = 3'h1;
  localparam logic [2:0] CFG_PR = 3'h2;
  localparam int LOW_VOLT_BIT   = 2;
  localparam int DEBUG_BIT      = 7;
  localparam int EE_RD_PROT_BIT  = 7;
  localparam int EE_WR_PROT_BIT  = 6;
  localparam int CFG_WR_PROT_BIT = 5;
  localparam logic [2:0] CP_BLOCKS = 3'h5;
  localparam logic [7:0] ERASED    = 8'hff;

  // debugger reservations
  localparam logic [1:0] DBG_STACK_LEVELS = 2'h2;
  localparam logic [9:0] DBG_PROG_BYTES   = 10'h200;
  localparam logic [3:0] DBG_DATA_BYTES   = 4'ha;

  // serial frame: 20 bits in, lsb first, then 8 answer bits out
  localparam logic [4:0] FRAME_BITS = 5'h14;
  localparam logic [4:0] LAST_BIT   = 5'h1b;

  // command codes
  localparam logic [3:0] CMD_RD_EE   = 4'h1;
  localparam logic [3:0] CMD_WR_EE   = 4'h2;
  localparam logic [3:0] CMD_RD_ID   = 4'h3;
  localparam logic [3:0] CMD_WR_ID   = 4'h4;
  localparam logic [3:0] CMD_RD_CFG  = 4'h5;
  localparam logic [3:0] CMD_WR_CFG  = 4'h6;
  localparam logic [3:0] CMD_ERASE   = 4'h7;
  localparam logic [3:0] CMD_ROW_ER  = 4'h8;
  localparam logic [3:0] CMD_RD_CODE = 4'h9;

  // pin slots: 0 mode pin, 1 clock line, 2 data line, 3 high voltage detect
  localparam int PIN_MODE = 0;
  localparam int PIN_CLK  = 1;
  localparam int PIN_DAT  = 2;
  localparam int PIN_HV   = 3;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] addr;
    logic [3:0] cmd;
  } pap_req_t;

endpackage : pap_pkg

// file: rtl/pap_access_guard.sv
// program access protection: gates serial programmer and processor access to
// data eeprom, id bytes and configuration bytes; controls programming entry.
// assumes hclk 50 MHz, programmer clock far slower, pins sampled through three flops.
// Summary of operation
// - eeprom read protect refuses external eeprom reads and writes
// - eeprom write protect refuses external eeprom writes
// - processor always reads and writes eeprom freely
// - config write protect blocks configuration writes
// - config write protect bit is read-only to the processor
// - eight user id bytes live in configuration space
// - id bytes readable and writable by processor and programmer
// - id reads succeed even under code protection
// - debugger enabled only when debug bit is zero
// - debugger reserves stack, program, data memory and clock/data pins
// - bit 2 of configuration byte four low enables low-voltage programming
// - low-voltage enable takes the mode pin away from general i/o
// - erased device has low-voltage programming enabled
// - high voltage on master clear always enters programming
// - with low-voltage enable clear the mode pin is ordinary i/o
// - low-voltage enable bit changes only under high-voltage programming
// - code-protected memory erasable only by block erase
// - serial programming uses one clock and one two-way data line
// - code protect bits go only 1 to 0; erase restores them
// - code protect bits block only external program memory access
module pap_access_guard #(
  parameter int EE_DEPTH = 256
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        high_program_voltage,
  input  wire logic [2:0]  pin_in,
  output logic      [2:0]  pin_out,
  output logic      [2:0]  pin_oe_n,
  input  wire logic [2:0]  gpio_out,
  input  wire logic [2:0]  gpio_oe_n,
  output logic      [2:0]  gpio_in,
  output logic             prog_active,
  output logic             debug_en,
  output logic      [1:0]  dbg_stack_levels,
  output logic      [9:0]  dbg_prog_bytes,
  output logic      [3:0]  dbg_data_bytes
);

  localparam int EA = $clog2(EE_DEPTH);

  if (EE_DEPTH < 2 || EE_DEPTH > 256 || (1 << EA) != EE_DEPTH)
    $error("EE_DEPTH must be a power of two from 2 to 256");

  // configuration merge: protection bytes only clear, some bits locked
  function automatic logic [7:0] cfg_merge(input logic [2:0] idx, input logic [7:0] old,
                                           input logic [7:0] nw, input logic ext_hv,
                                           input logic ext);
    logic [7:0] m;
    m = nw;
    if (idx == pap_pkg::CFG_CP || idx == pap_pkg::CFG_PR)
      m = old & nw;
    if (idx == pap_pkg::CFG_PR && !ext)
      m[pap_pkg::CFG_WR_PROT_BIT] = old[pap_pkg::CFG_WR_PROT_BIT];
    if (idx == pap_pkg::CFG_4L && !ext_hv)
      m[pap_pkg::LOW_VOLT_BIT] = old[pap_pkg::LOW_VOLT_BIT];
    return m;
  endfunction : cfg_merge

  // true for commands that return memory contents
  function automatic logic is_read(input logic [3:0] c);
    return c == pap_pkg::CMD_RD_EE || c == pap_pkg::CMD_RD_ID || c == pap_pkg::CMD_RD_CFG;
  endfunction : is_read

  logic [3:0]                  s1_q, s2_q, s3_q, filt_q;
  logic [3:0]                  s1_d, s2_d, s3_d, filt_d;
  logic [EE_DEPTH-1:0][7:0]    ee_q, ee_d;
  logic [pap_pkg::ID_BYTES-1:0][7:0]  id_q, id_d;
  logic [pap_pkg::CFG_BYTES-1:0][7:0] cfg_q, cfg_d;
  logic [4:0]                  cnt_q, cnt_d;
  logic [19:0]                 frame_q, frame_d;
  logic [7:0]                  resp_q, resp_d;
  logic                        dout_q, dout_d;
  logic [7:0]                  refused_q, refused_d;
  logic                        last_ref_q, last_ref_d;
  logic [8:0]                  crd_q, crd_d;
  logic                        dph_cmd_q, dph_cmd_d;
  logic [31:0]                 hrdata_d;
  logic [2:0]                  pin_out_d, pin_oe_n_d, gpio_in_d;
  logic                        prog_d, dbg_d;
  logic                        hv, rise, fall, ext_fire, cpu_fire, go, ext, ok, aph, drive;
  logic                        low_volt_prog_enable, eeprom_read_protect, eeprom_write_protect, config_write_protect;
  logic [7:0]                  rd, rdata;
  logic [EA-1:0]               ea;
  pap_pkg::pap_req_t           req;

  // next state of the whole block
  always_comb
  begin
    s1_d     = {high_program_voltage, pin_in};
    s2_d     = s1_q;
    s3_d     = s2_q;
    // a pin change counts only once the second and third stages agree
    filt_d   = (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
    hv       = filt_q[pap_pkg::PIN_HV];
    low_volt_prog_enable = cfg_q[pap_pkg::CFG_4L][pap_pkg::LOW_VOLT_BIT];
    // high voltage always wins; the mode pin only counts with low-voltage entry enabled
    prog_d   = hv || (low_volt_prog_enable && filt_q[pap_pkg::PIN_MODE]);
    dbg_d    = !cfg_q[pap_pkg::CFG_4L][pap_pkg::DEBUG_BIT];
    eeprom_read_protect  = !cfg_q[pap_pkg::CFG_PR][pap_pkg::EE_RD_PROT_BIT];
    eeprom_write_protect = !cfg_q[pap_pkg::CFG_PR][pap_pkg::EE_WR_PROT_BIT];
    config_write_protect = !cfg_q[pap_pkg::CFG_PR][pap_pkg::CFG_WR_PROT_BIT];
    rise     = filt_d[pap_pkg::PIN_CLK] && !filt_q[pap_pkg::PIN_CLK];
    fall     = !filt_d[pap_pkg::PIN_CLK] && filt_q[pap_pkg::PIN_CLK];
    ext_fire = prog_active && rise && cnt_q == pap_pkg::FRAME_BITS - 5'h01;
    // the serial side owns the single write port; the bus waits a cycle
    hreadyout = !(dph_cmd_q && ext_fire);
    cpu_fire = dph_cmd_q && !ext_fire;
    go       = ext_fire || cpu_fire;
    ext      = ext_fire;
    req      = ext_fire ? pap_pkg::pap_req_t'({filt_d[pap_pkg::PIN_DAT], frame_q[19:1]})
                        : pap_pkg::pap_req_t'(hwdata[19:0]);
    ea       = req.addr[EA-1:0];
    ee_d     = ee_q;
    id_d     = id_q;
    cfg_d    = cfg_q;
    ok       = 1'b1;
    rd       = 8'h00;
    case (req.cmd)
      pap_pkg::CMD_RD_EE:
      begin
        ok = !(ext && eeprom_read_protect);
        rd = ee_q[ea];
      end
      pap_pkg::CMD_WR_EE:
      begin
        ok = !(ext && (eeprom_read_protect || eeprom_write_protect));
        if (go && ok)
          ee_d[ea] = req.data;
      end
      pap_pkg::CMD_RD_ID:
        rd = id_q[req.addr[2:0]];
      pap_pkg::CMD_WR_ID:
        if (go)
          id_d[req.addr[2:0]] = req.data;
      pap_pkg::CMD_RD_CFG:
        rd = cfg_q[req.addr[2:0]];
      pap_pkg::CMD_WR_CFG:
      begin
        ok = !config_write_protect;
        if (go && ok)
          cfg_d[req.addr[2:0]] = cfg_merge(req.addr[2:0], cfg_q[req.addr[2:0]], req.data, ext && hv, ext);
      end
      pap_pkg::CMD_ERASE:
      begin
        ok = ext;
        if (go && ok)
        begin
          ee_d  = '1;
          id_d  = '1;
          cfg_d = '1;
        end
      end
      pap_pkg::CMD_ROW_ER:
      begin
        // a row erase cannot lift protection, so read-protected data needs a block erase
        ok = ext && !eeprom_read_protect;
        if (go && ok)
          ee_d[ea] = pap_pkg::ERASED;
      end
      pap_pkg::CMD_RD_CODE:
        ok = !(ext && req.addr[2:0] < pap_pkg::CP_BLOCKS && !cfg_q[pap_pkg::CFG_CP][req.addr[2:0]]);
      default:
        ok = 1'b0;
    endcase
    rdata = !ok ? 8'h00 : is_read(req.cmd) ? rd : 8'h01;

    // serial frame counter: 20 bits in, then 8 answer bits out
    cnt_d   = cnt_q;
    frame_d = frame_q;
    resp_d  = resp_q;
    dout_d  = dout_q;
    if (!prog_active)
    begin
      cnt_d  = 5'h00;
      dout_d = 1'b0;
    end
    else if (rise)
    begin
      if (cnt_q < pap_pkg::FRAME_BITS)
        frame_d = {filt_d[pap_pkg::PIN_DAT], frame_q[19:1]};
      cnt_d = (cnt_q == pap_pkg::LAST_BIT) ? 5'h00 : cnt_q + 5'h01;
    end
    else if (fall && cnt_q > pap_pkg::FRAME_BITS)
    begin
      resp_d = {1'b0, resp_q[7:1]};
      dout_d = resp_q[1];
    end
    if (ext_fire)
    begin
      resp_d = rdata;
      dout_d = rdata[0];
    end
    drive = prog_d && cnt_d >= pap_pkg::FRAME_BITS;

    refused_d  = (ext_fire && !ok) ? refused_q + 8'h01 : refused_q;
    last_ref_d = ext_fire ? !ok : last_ref_q;
    crd_d      = cpu_fire ? {ok, rdata} : crd_q;

    // ahb slave: zero wait except when the serial side holds the write port
    aph       = hsel && htrans[1] && hready;
    dph_cmd_d = hready ? (aph && hwrite && haddr[7:0] == pap_pkg::REG_CMD) : dph_cmd_q;
    hrdata_d  = 32'h0000_0000;
    if (aph && !hwrite)
      case (haddr[7:0])
        pap_pkg::REG_CFG:   hrdata_d = {cfg_d[3], cfg_d[2], cfg_d[1], cfg_d[0]};
        pap_pkg::REG_RDATA: hrdata_d = {23'h000000, crd_d};
        pap_pkg::REG_STAT:  hrdata_d = {16'h0000, refused_d, 3'h0, last_ref_d, dbg_d,
                                        low_volt_prog_enable, hv, prog_d};
        default:            hrdata_d = 32'h0000_0000;
      endcase

    // pin ownership
    pin_out_d  = {prog_d ? dout_d : gpio_out[2], gpio_out[1:0]};
    pin_oe_n_d[0] = low_volt_prog_enable ? 1'b1 : gpio_oe_n[0];
    pin_oe_n_d[1] = (prog_d || dbg_d) ? 1'b1 : gpio_oe_n[1];
    pin_oe_n_d[2] = prog_d ? !drive : dbg_d ? 1'b1 : gpio_oe_n[2];
    // reserved pins read as zero to the port so software sees no stray levels
    gpio_in_d  = filt_q[2:0] & ~{prog_d || dbg_d, prog_d || dbg_d, low_volt_prog_enable};
  end

  // registers; configuration resets to its erased image
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_q             <= 4'h0;
      s2_q             <= 4'h0;
      s3_q             <= 4'h0;
      filt_q           <= 4'h0;
      ee_q             <= '1;
      id_q             <= '1;
      cfg_q            <= '1;
      cnt_q            <= 5'h00;
      frame_q          <= 20'h00000;
      resp_q           <= 8'h00;
      dout_q           <= 1'b0;
      refused_q        <= 8'h00;
      last_ref_q       <= 1'b0;
      crd_q            <= 9'h000;
      dph_cmd_q        <= 1'b0;
      hrdata           <= 32'h0000_0000;
      pin_out          <= 3'h0;
      pin_oe_n         <= 3'h7;
      gpio_in          <= 3'h0;
      prog_active      <= 1'b0;
      debug_en         <= 1'b0;
      dbg_stack_levels <= 2'h0;
      dbg_prog_bytes   <= 10'h000;
      dbg_data_bytes   <= 4'h0;
    end
    else
    begin
      s1_q             <= s1_d;
      s2_q             <= s2_d;
      s3_q             <= s3_d;
      filt_q           <= filt_d;
      ee_q             <= ee_d;
      id_q             <= id_d;
      cfg_q            <= cfg_d;
      cnt_q            <= cnt_d;
      frame_q          <= frame_d;
      resp_q           <= resp_d;
      dout_q           <= dout_d;
      refused_q        <= refused_d;
      last_ref_q       <= last_ref_d;
      crd_q            <= crd_d;
      dph_cmd_q        <= dph_cmd_d;
      hrdata           <= hready ? hrdata_d : hrdata;
      pin_out          <= pin_out_d;
      pin_oe_n         <= pin_oe_n_d;
      gpio_in          <= gpio_in_d;
      prog_active      <= prog_d;
      debug_en         <= dbg_d;
      dbg_stack_levels <= dbg_d ? pap_pkg::DBG_STACK_LEVELS : 2'h0;
      dbg_prog_bytes   <= dbg_d ? pap_pkg::DBG_PROG_BYTES : 10'h000;
      dbg_data_bytes   <= dbg_d ? pap_pkg::DBG_DATA_BYTES : 4'h0;
    end
  end

  assign hresp = 1'b0;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_ext_rd(logic [3:0] c);
    ext_fire && req.cmd == c;
  endsequence
  sequence s_answer_out;
    ##1 !pin_oe_n[2] ##1 prog_active;
  endsequence

  property p_ee_rd_prot;
    s_ext_rd(pap_pkg::CMD_RD_EE) and eeprom_read_protect |=> resp_q == 8'h00 && refused_q == $past(refused_q) + 8'h01;
  endproperty
  a_ee_rd_prot: assert property (p_ee_rd_prot) else $error("protected eeprom read answered");
  property p_ee_wr_prot;
    s_ext_rd(pap_pkg::CMD_WR_EE) and eeprom_write_protect |=> $stable(ee_q) && resp_q == 8'h00;
  endproperty
  a_ee_wr_prot: assert property (p_ee_wr_prot) else $error("protected eeprom write done");
  property p_cpu_ee;
    cpu_fire && req.cmd == pap_pkg::CMD_WR_EE |=> crd_q[8] && ee_q[$past(ea)] == $past(req.data);
  endproperty
  a_cpu_ee: assert property (p_cpu_ee) else $error("processor eeprom write lost");
  property p_cfg_wp;
    go && req.cmd == pap_pkg::CMD_WR_CFG && config_write_protect |=> $stable(cfg_q);
  endproperty
  a_cfg_wp: assert property (p_cfg_wp) else $error("configuration written while protected");
  property p_config_write_protect_ro;
    cpu_fire |=> cfg_q[pap_pkg::CFG_PR][pap_pkg::CFG_WR_PROT_BIT]
                 == $past(cfg_q[pap_pkg::CFG_PR][pap_pkg::CFG_WR_PROT_BIT]);
  endproperty
  a_config_write_protect_ro: assert property (p_config_write_protect_ro) else $error("processor changed config write protect");
  property p_id_rd;
    s_ext_rd(pap_pkg::CMD_RD_ID) |=> resp_q == $past(id_q[req.addr[2:0]]);
  endproperty
  a_id_rd: assert property (p_id_rd) else $error("id read masked");
  property p_mode_pin;
    low_volt_prog_enable |=> pin_oe_n[0] && !gpio_in[0];
  endproperty
  a_mode_pin: assert property (p_mode_pin) else $error("mode pin left to general i/o");
  property p_hv_entry;
    hv |=> prog_active;
  endproperty
  a_hv_entry: assert property (p_hv_entry) else $error("high voltage entry refused");
  property p_low_volt_lock;
    go && !(ext && hv) |=> cfg_q[pap_pkg::CFG_4L][pap_pkg::LOW_VOLT_BIT] == $past(low_volt_prog_enable)
                           || $past(req.cmd) == pap_pkg::CMD_ERASE;
  endproperty
  a_low_volt_lock: assert property (p_low_volt_lock) else $error("low-voltage enable changed outside high voltage");
  property p_answer;
    ext_fire && !hv && low_volt_prog_enable |-> s_answer_out;
  endproperty
  a_answer: assert property (p_answer) else $error("data line not driven for answer");

endmodule : pap_access_guard

// file: sim/pap_programmer.sv
// serial programmer model: mode pin, clock line, two-way data line, high voltage.
// assumes it and the guard's pins are the only drivers of each wire.
module pap_programmer (
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe_n,
  output logic      [2:0] pin_lvl,
  output logic            hv
);
  timeunit 1ns;
  timeprecision 1ns;
  // half period of 4 device clocks (160 ns link period); each level still gets two agreeing sync samples
  localparam int HALF = 80;
  logic mode, clk_l, dat, dat_oe, last;
  // device drive wins; a released data line shows the inverse of its last level
  assign pin_lvl[0] = pin_oe_n[0] ? mode : pin_out[0];
  assign pin_lvl[1] = pin_oe_n[1] ? clk_l : pin_out[1];
  assign pin_lvl[2] = !pin_oe_n[2] ? pin_out[2] : dat_oe ? dat : ~last;
  always @(pin_lvl[2])
    if (!pin_oe_n[2] || dat_oe)
      last = pin_lvl[2];
  // board holds the mode pin low, clock idles low
  initial
  begin
    mode   = 1'b0;
    hv     = 1'b0;
    clk_l  = 1'b0;
    dat    = 1'b0;
    dat_oe = 1'b0;
    last   = 1'b0;
  end
  // entry levels; moved a few ns off the device clock edge
  task automatic enter(input logic use_hv, input logic use_mode);
    #3;
    hv   = use_hv;
    mode = use_mode;
  endtask : enter
  // 20 bits out lsb first, then 8 answer bits on the next rises; offset keeps edges off hclk
  task automatic frame(input logic [19:0] bits, output logic [7:0] ans);
    #7;
    for (int i = 0; i < 28; i++)
    begin
      dat_oe = (i < 20);
      if (i < 20)
        dat = bits[i];
      #HALF clk_l = 1'b1;
      if (i >= 20)
        ans[i-20] = pin_lvl[2];
      #HALF clk_l = 1'b0;
    end
    dat_oe = 1'b0;
  endtask : frame
endmodule : pap_programmer

// file: sim/tb_top.sv
// testbench: register bus master plus serial programmer model around the guard.
// assumes pap_pkg, the guard and pap_programmer are compiled before it.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, hv, prog_active, debug_en;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans, dbg_stack_levels;
  logic [2:0]  pin_lvl, pin_out, pin_oe_n, gpio_out, gpio_oe_n, gpio_in;
  logic [9:0]  dbg_prog_bytes;
  logic [3:0]  dbg_data_bytes;
  logic [7:0]  a, d, x, v, ans;
  int          mismatches, n_checks, seed;

  pap_access_guard u_pap_access_guard (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .high_program_voltage(hv), .pin_in(pin_lvl),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
    .gpio_in(gpio_in), .prog_active(prog_active), .debug_en(debug_en),
    .dbg_stack_levels(dbg_stack_levels), .dbg_prog_bytes(dbg_prog_bytes),
    .dbg_data_bytes(dbg_data_bytes));
  pap_programmer u_pap_programmer (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_lvl(pin_lvl), .hv(hv));

  initial hclk = 1'b0;
  always #10 hclk = ~hclk;

  task automatic print_verdict();
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // expected data-phase word of the result register
  function automatic logic [31:0] okv(input logic ok, input logic [7:0] val);
    return ok ? {23'h0, 1'b1, val} : 32'h0;
  endfunction : okv
  // one single transfer; address held until ready, read data taken at the data edge
  task automatic ahb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, adr};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic cpu(input logic [3:0] c, input logic [7:0] aa, input logic [7:0] dd);
    ahb(1'b1, pap_pkg::REG_CMD, {12'h0, dd, aa, c});
    ahb(1'b0, pap_pkg::REG_RDATA, 32'h0);
  endtask : cpu
  task automatic ser(input logic [3:0] c, input logic [7:0] aa, input logic [7:0] dd);
    u_pap_programmer.frame({dd, aa, c}, ans);
    @(posedge hclk);
  endtask : ser
  task automatic sc(input logic [7:0] e);
    chk({24'h0, ans}, {24'h0, e});
  endtask : sc
  // programming state settles through the pin synchroniser
  task automatic waitp(input logic e);
    for (int i = 0; i < 30 && prog_active !== e; i++)
      @(posedge hclk);
    chk({31'h0, prog_active}, {31'h0, e});
  endtask : waitp

  // main sequence
  initial
  begin
    seed = 47;
    mismatches = 0;
    n_checks = 0;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    gpio_out = 3'h0;
    gpio_oe_n = 3'h7;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    ahb(1'b0, pap_pkg::REG_CFG, 32'h0);
    chk(r, 32'hffffffff);
    chk({31'h0, hresp}, 32'h0);
    ahb(1'b0, pap_pkg::REG_STAT, 32'h0);
    chk({31'h0, r[2]}, 32'h1);
    chk({31'h0, debug_en}, 32'h0);
    // software cannot take the mode pin (slot 0) while low-voltage entry is on
    gpio_out <= 3'($random(seed));
    gpio_oe_n <= 3'h6;
    repeat (4) @(posedge hclk);
    chk({31'h0, pin_oe_n[0]}, 32'h1);
    repeat (4)
    begin
      a = 8'($random(seed));
      d = 8'($random(seed));
      cpu(pap_pkg::CMD_WR_EE, a, d);
      chk(r, okv(1'b1, 8'h01));
      cpu(pap_pkg::CMD_RD_EE, a, 8'h0);
      chk(r, okv(1'b1, d));
    end
    u_pap_programmer.enter(1'b0, 1'b1);
    waitp(1'b1);
    ser(pap_pkg::CMD_RD_EE, a, 8'h0);
    sc(d);
    v = 8'($random(seed));
    ser(pap_pkg::CMD_WR_ID, 8'h5, v);
    sc(8'h01);
    cpu(pap_pkg::CMD_RD_ID, 8'h5, 8'h0);
    chk(r, okv(1'b1, v));
    ser(pap_pkg::CMD_RD_ID, 8'h5, 8'h0);
    sc(v);
    // write protect alone: external writes refused, reads and processor unaffected
    ser(pap_pkg::CMD_WR_CFG, 8'h2, 8'hbf);
    x = ~d;
    ser(pap_pkg::CMD_WR_EE, a, x);
    sc(8'h00);
    ser(pap_pkg::CMD_RD_EE, a, 8'h0);
    sc(d);
    cpu(pap_pkg::CMD_WR_EE, a, x);
    chk(r, okv(1'b1, 8'h01));
    // read protect: every external eeprom access refused
    ser(pap_pkg::CMD_WR_CFG, 8'h2, 8'h7f);
    ser(pap_pkg::CMD_RD_EE, a, 8'h0);
    sc(8'h00);
    ser(pap_pkg::CMD_WR_EE, a, d);
    sc(8'h00);
    ser(pap_pkg::CMD_ROW_ER, a, 8'h0);
    sc(8'h00);
    cpu(pap_pkg::CMD_RD_EE, a, 8'h0);
    chk(r, okv(1'b1, x));
    ser(pap_pkg::CMD_WR_CFG, 8'h1, 8'h00);
    ser(pap_pkg::CMD_RD_ID, 8'h5, 8'h0);
    sc(v);
    for (int b = 0; b < 5; b++)
    begin
      ser(pap_pkg::CMD_RD_CODE, 8'(b), 8'h0);
      sc(8'h00);
    end
    // only a block erase brings protection back to ones
    ser(pap_pkg::CMD_ERASE, 8'h0, 8'h0);
    ser(pap_pkg::CMD_RD_CFG, 8'h1, 8'h0);
    sc(8'hff);
    ser(pap_pkg::CMD_RD_EE, a, 8'h0);
    sc(8'hff);
    ser(pap_pkg::CMD_WR_CFG, 8'h0, 8'h7b);
    ser(pap_pkg::CMD_RD_CFG, 8'h0, 8'h0);
    sc(8'h7f);
    chk({31'h0, debug_en}, 32'h1);
    chk({16'h0, dbg_stack_levels, dbg_prog_bytes, dbg_data_bytes}, {16'h0, 2'h2, 10'h200, 4'ha});
    u_pap_programmer.enter(1'b1, 1'b1);
    ser(pap_pkg::CMD_WR_CFG, 8'h0, 8'h7b);
    ahb(1'b0, pap_pkg::REG_STAT, 32'h0);
    chk({31'h0, r[2]}, 32'h0);
    u_pap_programmer.enter(1'b0, 1'b1);
    waitp(1'b0);
    u_pap_programmer.enter(1'b0, 1'b0);
    repeat (8) @(posedge hclk);
    chk({30'h0, pin_oe_n[0], pin_out[0]}, {30'h0, 1'b0, gpio_out[0]});
    chk({31'h0, gpio_in[0]}, {31'h0, gpio_out[0]});
    u_pap_programmer.enter(1'b1, 1'b0);
    waitp(1'b1);
    // processor may only clear protection bits and never the config write protect
    cpu(pap_pkg::CMD_WR_CFG, 8'h2, 8'h00);
    cpu(pap_pkg::CMD_WR_CFG, 8'h1, 8'hfe);
    cpu(pap_pkg::CMD_WR_CFG, 8'h1, 8'hff);
    ahb(1'b0, pap_pkg::REG_CFG, 32'h0);
    chk({24'h0, r[23:16]}, 32'h20);
    chk({24'h0, r[15:8]}, 32'hfe);
    ser(pap_pkg::CMD_WR_CFG, 8'h2, 8'hdf);
    ser(pap_pkg::CMD_WR_CFG, 8'h1, 8'h00);
    sc(8'h00);
    cpu(pap_pkg::CMD_WR_CFG, 8'h1, 8'h00);
    chk(r, okv(1'b0, 8'h00));
    ser(pap_pkg::CMD_RD_CFG, 8'h1, 8'h0);
    sc(8'hfe);
    print_verdict();
  end

  // about 26 frames of some 230 clocks each fit well inside this limit
  initial
  begin
    repeat (60000) @(posedge hclk);
    mismatches++;
    print_verdict();
  end
endmodule : tb_top
